//--- verilog/split_timer_pkg.sv
// Purpose: Shared constants and types for the split timer block
// Assumes: One timer module per top instance; twelve modules share one sync mask
// Notes: Narrow modules use 16-bit halves, wide modules 32-bit halves
package split_timer_pkg;
    localparam int NARROW_HALF_W = 16;
    localparam int WIDE_HALF_W = 32;
    localparam int NARROW_PRE_W = 8;
    localparam int WIDE_PRE_W = 16;
    localparam int SYNC_BITS = 24;
    localparam int MODULES_PER_KIND = 6;
    localparam int WIDE_SYNC_BASE = 12;
    localparam int SYNC_A_OFS = 0;
    localparam int SYNC_B_OFS = 1;
    localparam int SYNC_BITS_PER_MODULE = 2;
    localparam logic [1:0] SEL_A = 2'h1;
    localparam logic [1:0] SEL_B = 2'h2;

    typedef enum logic [3:0] {
        MODE_ONESHOT = 4'h1,
        MODE_PERIODIC = 4'h2,
        MODE_RTC = 4'h4,
        MODE_EDGECOUNT = 4'h8
    } mode_t;

    typedef enum logic [1:0] {
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_t;
endpackage

//--- verilog/timer_half.sv
// Purpose: One timer half: combined counter with prescaler, match and capture edges
// Assumes: Load, match and prescale values are held stable by the parent
// Notes: Full width disables the prescaler and widens the counter to FW bits
`timescale 1ns/1ps
`default_nettype none
module timer_half #(
    parameter int HW = 16,
    parameter int PW = 8,
    parameter int FW = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic fullMode,
    input wire split_timer_pkg::mode_t mode,
    input wire split_timer_pkg::edge_t edgeSel,
    input wire logic countUp,
    input wire logic run,
    input wire logic [FW-1:0] loadVal,
    input wire logic [PW-1:0] preVal,
    input wire logic [FW-1:0] matchVal,
    input wire logic [PW-1:0] preMatch,
    input wire logic loadNow,
    input wire logic syncNow,
    input wire logic capIn,
    output logic [FW-1:0] countVal,
    output logic [PW-1:0] preCount,
    output logic timeout,
    output logic matchHit
);
    localparam int RW = FW + PW;
    localparam logic [RW-1:0] FULL_MASK = RW'({FW{1'b1}});
    localparam logic [RW-1:0] HALF_MASK = RW'({(HW + PW){1'b1}});
    localparam logic [RW-1:0] ONE = RW'(1);

    logic [RW-1:0] comb_reg;
    logic stopped_reg;
    logic capPrev_reg;
    logic [RW-1:0] loadComb, matchComb, limit;
    logic lsbPre, edgeHit, step, terminal;

    always_comb begin
        lsbPre = !countUp && (mode == split_timer_pkg::MODE_ONESHOT ||
                              mode == split_timer_pkg::MODE_PERIODIC);
        limit = fullMode ? FULL_MASK : HALF_MASK;
        if (fullMode) begin
            loadComb = RW'(loadVal);
            matchComb = RW'(matchVal);
        end else if (lsbPre) begin
            loadComb = RW'({loadVal[HW-1:0], preVal});
            matchComb = RW'({matchVal[HW-1:0], preMatch});
        end else begin
            loadComb = RW'({preVal, loadVal[HW-1:0]});
            matchComb = RW'({preMatch, matchVal[HW-1:0]});
        end
        unique case (edgeSel)
            split_timer_pkg::EDGE_RISE: edgeHit = capIn && !capPrev_reg;
            split_timer_pkg::EDGE_FALL: edgeHit = !capIn && capPrev_reg;
            split_timer_pkg::EDGE_BOTH: edgeHit = capIn != capPrev_reg;
            default: edgeHit = 1'b0;
        endcase
        step = (mode == split_timer_pkg::MODE_EDGECOUNT) ? edgeHit : 1'b1;
        terminal = countUp ? (comb_reg == (loadComb & limit)) : (comb_reg == '0);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            capPrev_reg <= 1'b0;
        end else begin
            capPrev_reg <= capIn;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            comb_reg <= '0;
            stopped_reg <= 1'b0;
            timeout <= 1'b0;
        end else begin
            timeout <= 1'b0;
            if (syncNow) begin
                comb_reg <= countUp ? '0 : (loadComb & limit);
                stopped_reg <= 1'b0;
            end else if (loadNow) begin
                comb_reg <= loadComb & limit;
                stopped_reg <= 1'b0;
            end else if (run && step && !stopped_reg) begin
                if (terminal) begin
                    timeout <= 1'b1;
                    if (mode == split_timer_pkg::MODE_ONESHOT) begin
                        stopped_reg <= 1'b1;
                    end else begin
                        comb_reg <= countUp ? '0 : (loadComb & limit);
                    end
                end else begin
                    comb_reg <= countUp ? ((comb_reg + ONE) & limit) : ((comb_reg - ONE) & limit);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            matchHit <= 1'b0;
        end else begin
            matchHit <= (comb_reg == (matchComb & limit));
        end
    end

    always_comb begin
        if (fullMode) begin
            countVal = comb_reg[FW-1:0];
            preCount = '0;
        end else if (lsbPre) begin
            countVal = FW'(comb_reg[PW +: HW]);
            preCount = comb_reg[PW-1:0];
        end else begin
            countVal = FW'(comb_reg[HW-1:0]);
            preCount = comb_reg[HW +: PW];
        end
    end

    property p_syncReload;
        @(posedge clk) disable iff (!rstn)
        syncNow && !countUp |=> comb_reg == $past(loadComb & limit);
    endproperty
    a_syncReload: assert property (p_syncReload) else $error("sync did not reload counter");

    property p_loadImmediate;
        @(posedge clk) disable iff (!rstn)
        loadNow && !syncNow |=> comb_reg == $past(loadComb & limit);
    endproperty
    a_loadImmediate: assert property (p_loadImmediate) else $error("load not applied at once");

    property p_halted;
        @(posedge clk) disable iff (!rstn)
        !run && !loadNow && !syncNow |=> $stable(comb_reg);
    endproperty
    a_halted: assert property (p_halted) else $error("counter moved while halted");

    property p_noPreFull;
        @(posedge clk) disable iff (!rstn)
        fullMode |-> preCount == '0 && comb_reg[RW-1:FW] == '0;
    endproperty
    a_noPreFull: assert property (p_noPreFull) else $error("prescaler active in full width");

    property p_lsbOrder;
        @(posedge clk) disable iff (!rstn)
        !fullMode && lsbPre && loadNow && !syncNow
            |=> preCount == $past(preVal) && countVal == FW'($past(loadVal[HW-1:0]));
    endproperty
    a_lsbOrder: assert property (p_lsbOrder) else $error("prescaler not in low bits");
endmodule
`default_nettype wire

//--- verilog/split_timer.sv
// Purpose: One split timer module with prescaler, calendar run control and sync fan-out
// Assumes: Module 0 gets IS_FIRST=1 and feeds its syncOut to every module's syncIn
// Notes: Writes steer half A, half B or both via wrSel; full width uses only A
//
// Contract
// - prescaler acts only in half-width operation
// - prescale range 255 narrow, 65535 wide
// - down periodic/one-shot: prescaler is low bits
// - other half modes: prescaler is high bits
// - calendar enable cleared stops and holds count
// - calendar enable starts only in calendar mode
// - sync control lives only in first module
// - sync hits exactly the selected counters
// - half-width A and B selected independently
// - full width: only A select bit acts, except on prescale and prescale match writes
// - 24 select bits, twelve modules
// - value read is live count, A in full
// - full width uses only A registers
// - wide full width gives 64-bit count
// - prescale writable to A, B or both
// - prescale match extends match like prescaler
// - load write while running applies immediately
`timescale 1ns/1ps
`default_nettype none
module split_timer #(
    parameter int HW = split_timer_pkg::NARROW_HALF_W,
    parameter int MODULE_INDEX = 0,
    parameter bit IS_FIRST = 1'b0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic fullWidth,
    input wire split_timer_pkg::mode_t modeA,
    input wire split_timer_pkg::mode_t modeB,
    input wire logic countUpA,
    input wire logic countUpB,
    input wire split_timer_pkg::edge_t edgeSelA,
    input wire split_timer_pkg::edge_t edgeSelB,
    input wire logic enableA,
    input wire logic enableB,
    input wire logic calendarEnSet,
    input wire logic calendarEnClr,
    input wire logic captureA,
    input wire logic captureB,
    input wire logic [1:0] wrSel,
    input wire logic loadWr,
    input wire logic matchWr,
    input wire logic preWr,
    input wire logic preMatchWr,
    input wire logic [2*HW-1:0] wrData,
    input wire logic syncWrite,
    input wire logic [split_timer_pkg::SYNC_BITS-1:0] syncMask,
    input wire logic [split_timer_pkg::SYNC_BITS-1:0] syncIn,
    output logic [split_timer_pkg::SYNC_BITS-1:0] syncOut,
    output logic [2*HW-1:0] valueA,
    output logic [HW-1:0] valueB,
    output logic [HW/2-1:0] preCountA,
    output logic [HW/2-1:0] preCountB,
    output logic calendarRunning,
    output logic timeoutA,
    output logic timeoutB,
    output logic matchA,
    output logic matchB
);
    localparam int PW = HW / 2;
    localparam int FW = 2 * HW;
    localparam bit WIDE = (HW == split_timer_pkg::WIDE_HALF_W);
    localparam int BIT_A = (WIDE ? split_timer_pkg::WIDE_SYNC_BASE : 0)
        + MODULE_INDEX * split_timer_pkg::SYNC_BITS_PER_MODULE + split_timer_pkg::SYNC_A_OFS;
    localparam int BIT_B = BIT_A - split_timer_pkg::SYNC_A_OFS + split_timer_pkg::SYNC_B_OFS;

    initial begin
        if (HW != split_timer_pkg::NARROW_HALF_W && HW != split_timer_pkg::WIDE_HALF_W) begin
            $error("HW must be the narrow or wide half width");
        end
        if (MODULE_INDEX < 0 || MODULE_INDEX >= split_timer_pkg::MODULES_PER_KIND) begin
            $error("MODULE_INDEX out of range");
        end
    end

    logic [FW-1:0] loadA_reg, matchA_reg;
    logic [HW-1:0] loadB_reg, matchB_reg;
    logic [PW-1:0] preA_reg, preB_reg, preMatchA_reg, preMatchB_reg;
    logic calendarEn_reg;
    logic loadNowA, loadNowB, syncA, syncB, runA, runB;
    logic wrA, wrB;
    logic [FW-1:0] valueBWide;
    logic [FW-1:0] loadANext;
    logic [HW-1:0] loadBNext;

    // Full width ignores the B selector so stray B writes cannot disturb A
    assign wrA = wrSel[0];
    assign wrB = wrSel[1] && !fullWidth;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            loadA_reg <= '0;
            loadB_reg <= '0;
        end else if (loadWr) begin
            if (wrA) begin
                loadA_reg <= fullWidth ? wrData : FW'(wrData[HW-1:0]);
            end
            if (wrB) begin
                loadB_reg <= wrData[HW-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            matchA_reg <= '0;
            matchB_reg <= '0;
        end else if (matchWr) begin
            if (wrA) begin
                matchA_reg <= fullWidth ? wrData : FW'(wrData[HW-1:0]);
            end
            if (wrB) begin
                matchB_reg <= wrData[HW-1:0];
            end
        end
    end

    // Prescale fields are PW wide, so values above the range cannot be stored
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            preA_reg <= '0;
            preB_reg <= '0;
        end else if (preWr) begin
            if (wrSel[0]) begin
                preA_reg <= wrData[PW-1:0];
            end
            if (wrSel[1]) begin
                preB_reg <= wrData[PW-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            preMatchA_reg <= '0;
            preMatchB_reg <= '0;
        end else if (preMatchWr) begin
            if (wrSel[0]) begin
                preMatchA_reg <= wrData[PW-1:0];
            end
            if (wrSel[1]) begin
                preMatchB_reg <= wrData[PW-1:0];
            end
        end
    end

    // Set wins over clear; set is refused outside calendar mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            calendarEn_reg <= 1'b0;
        end else if (calendarEnSet && modeA == split_timer_pkg::MODE_RTC) begin
            calendarEn_reg <= 1'b1;
        end else if (calendarEnClr || modeA != split_timer_pkg::MODE_RTC) begin
            calendarEn_reg <= 1'b0;
        end
    end
    assign calendarRunning = calendarEn_reg;

    // Only the first module latches the mask; the rest just listen
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncOut <= '0;
        end else begin
            syncOut <= (IS_FIRST && syncWrite) ? syncMask : '0;
        end
    end

    always_comb begin
        syncA = IS_FIRST ? syncOut[BIT_A] : syncIn[BIT_A];
        syncB = (IS_FIRST ? syncOut[BIT_B] : syncIn[BIT_B]) && !fullWidth;
        // Reload must see the value being written, not the stale register
        loadANext = (loadWr && wrA) ? (fullWidth ? wrData : FW'(wrData[HW-1:0])) : loadA_reg;
        loadBNext = (loadWr && wrB) ? wrData[HW-1:0] : loadB_reg;
        loadNowA = loadWr && wrA && enableA;
        loadNowB = loadWr && wrB && enableB;
        runA = enableA && (modeA != split_timer_pkg::MODE_RTC || calendarEn_reg);
        runB = enableB && !fullWidth &&
            (modeB != split_timer_pkg::MODE_RTC || calendarEn_reg);
    end

    // Half A carries the whole FW-bit count in full width
    timer_half #(.HW(HW), .PW(PW), .FW(FW)) halfA (
        .clk(clk),
        .rstn(rstn),
        .fullMode(fullWidth),
        .mode(modeA),
        .edgeSel(edgeSelA),
        .countUp(countUpA),
        .run(runA),
        .loadVal(loadANext),
        .preVal(preA_reg),
        .matchVal(matchA_reg),
        .preMatch(preMatchA_reg),
        .loadNow(loadNowA),
        .syncNow(syncA),
        .capIn(captureA),
        .countVal(valueA),
        .preCount(preCountA),
        .timeout(timeoutA),
        .matchHit(matchA)
    );

    timer_half #(.HW(HW), .PW(PW), .FW(HW)) halfB (
        .clk(clk),
        .rstn(rstn),
        .fullMode(1'b0),
        .mode(modeB),
        .edgeSel(edgeSelB),
        .countUp(countUpB),
        .run(runB),
        .loadVal(loadBNext),
        .preVal(preB_reg),
        .matchVal(matchB_reg),
        .preMatch(preMatchB_reg),
        .loadNow(loadNowB),
        .syncNow(syncB),
        .capIn(captureB),
        .countVal(valueB),
        .preCount(preCountB),
        .timeout(timeoutB),
        .matchHit(matchB)
    );

    assign valueBWide = FW'(valueB);

    property p_bIgnoredFull;
        @(posedge clk) disable iff (!rstn)
        fullWidth && $past(fullWidth) && $stable(modeB) && $stable(countUpB)
            |-> $stable(valueBWide);
    endproperty
    a_bIgnoredFull: assert property (p_bIgnoredFull) else $error("B half moved in full width");

    property p_rtcSetRefused;
        @(posedge clk) disable iff (!rstn)
        calendarEnSet && modeA != split_timer_pkg::MODE_RTC |=> !calendarRunning;
    endproperty
    a_rtcSetRefused: assert property (p_rtcSetRefused) else $error("calendar run outside mode");

    property p_rtcStart;
        @(posedge clk) disable iff (!rstn)
        calendarEnSet && modeA == split_timer_pkg::MODE_RTC |=> calendarRunning;
    endproperty
    a_rtcStart: assert property (p_rtcStart) else $error("calendar run did not start");

    property p_syncOnlyFirst;
        @(posedge clk) disable iff (!rstn)
        !IS_FIRST |-> syncOut == '0;
    endproperty
    a_syncOnlyFirst: assert property (p_syncOnlyFirst) else $error("sync issued by other module");

    property p_syncFanout;
        @(posedge clk) disable iff (!rstn)
        IS_FIRST && syncWrite |=> syncOut == $past(syncMask) ##1 syncOut == '0 || $past(syncWrite);
    endproperty
    a_syncFanout: assert property (p_syncFanout) else $error("sync mask not issued once");
endmodule
`default_nettype wire

//--- test/split_timer_prescale_rtc_sync_tb.sv
// Purpose: Self-checking bench for one wide split timer acting as the first module
// Assumes: syncOut loops back to syncIn; sync reload lands one edge after syncOut
// Notes: Prescale-match path is left idle; the bench budget goes to sync and prescale
`timescale 1ns/1ps
`default_nettype none
module split_timer_prescale_rtc_sync_tb;
    logic clk, rstn, fullWidth, countUpA, countUpB, enableA, enableB;
    logic calendarEnSet, calendarEnClr, captureA, captureB;
    logic loadWr, matchWr, preWr, preMatchWr, syncWrite, calendarRunning;
    logic timeoutA, matchB;
    split_timer_pkg::mode_t modeA, modeB;
    split_timer_pkg::edge_t edgeSelA, edgeSelB;
    logic [1:0] wrSel;
    logic [63:0] wrData, valueA, vA;
    logic [23:0] syncMask, syncOut;
    logic [31:0] valueB;
    logic [15:0] preCountA, preCountB, vP;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    split_timer #(.HW(32), .MODULE_INDEX(0), .IS_FIRST(1'b1)) dut (
        .clk(clk), .rstn(rstn), .fullWidth(fullWidth), .modeA(modeA), .modeB(modeB),
        .countUpA(countUpA), .countUpB(countUpB), .edgeSelA(edgeSelA), .edgeSelB(edgeSelB),
        .enableA(enableA), .enableB(enableB), .calendarEnSet(calendarEnSet),
        .calendarEnClr(calendarEnClr), .captureA(captureA), .captureB(captureB),
        .wrSel(wrSel), .loadWr(loadWr), .matchWr(matchWr), .preWr(preWr),
        .preMatchWr(preMatchWr), .wrData(wrData), .syncWrite(syncWrite),
        .syncMask(syncMask), .syncIn(syncOut), .syncOut(syncOut), .valueA(valueA),
        .valueB(valueB), .preCountA(preCountA), .preCountB(preCountB),
        .calendarRunning(calendarRunning), .timeoutA(timeoutA), .timeoutB(), .matchA(),
        .matchB(matchB)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hang in any wait ends the run through the same report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("[ERR] %0t run exceeded its cycle budget", $time);
            end_of_test();
        end
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic ld, input logic pre, input logic [1:0] sel,
                      input logic [63:0] d);
        @(posedge clk);
        loadWr <= ld;
        preWr <= pre;
        wrSel <= sel;
        wrData <= d;
        @(posedge clk);
        loadWr <= 1'b0;
        preWr <= 1'b0;
        #1;
    endtask

    // Leaves vA and vP as seen one edge before the selected counters reload
    task automatic sync(input logic [23:0] m);
        @(posedge clk);
        syncWrite <= 1'b1;
        syncMask <= m;
        @(posedge clk);
        syncWrite <= 1'b0;
        #1;
        vA = valueA;
        vP = preCountA;
        check(64'(syncOut), 64'(m));
        tick();
    endtask

    task automatic pulse(input logic s, input logic c);
        @(posedge clk);
        calendarEnSet <= s;
        calendarEnClr <= c;
        @(posedge clk);
        calendarEnSet <= 1'b0;
        calendarEnClr <= 1'b0;
        #1;
    endtask

    task automatic test_full();
        @(posedge clk);
        fullWidth <= 1'b1;
        enableA <= 1'b1;
        wr(1'b1, 1'b0, split_timer_pkg::SEL_A, 64'h1234_5678_9ABC_DEF0);
        check(valueA, 64'h1234_5678_9ABC_DEF0);
        check(64'(preCountA), 64'h0);
        tick();
        check(valueA, 64'h1234_5678_9ABC_DEEF);
        wr(1'b1, 1'b0, split_timer_pkg::SEL_B, 64'h55);
        check(valueA, 64'h1234_5678_9ABC_DEED);
        sync(24'h00_2000);
        check(valueA, vA - 64'h1);
        sync(24'h00_1000);
        check(valueA, 64'h1234_5678_9ABC_DEF0);
        $display("test full width done");
    endtask

    task automatic test_half();
        @(posedge clk);
        fullWidth <= 1'b0;
        enableB <= 1'b1;
        // Upper bits beyond the prescaler width must be dropped
        wr(1'b0, 1'b1, 2'h3, 64'h1_FFFF);
        wr(1'b1, 1'b0, 2'h3, 64'h40);
        check(64'(preCountA), 64'hFFFF);
        check(64'(preCountB), 64'hFFFF);
        check(64'(valueB), 64'h40);
        tick();
        check(64'(preCountA), 64'hFFFE);
        check(64'(valueA[31:0]), 64'h40);
        sync(24'h00_2000);
        check(64'(preCountB), 64'hFFFF);
        check(64'(preCountA), 64'(vP - 16'h1));
        @(posedge clk);
        countUpA <= 1'b1;
        sync(24'h00_1000);
        check(64'(valueA[31:0]), 64'h0);
        tick();
        check(64'(valueA[31:0]), 64'h1);
        check(64'(preCountA), 64'h0);
        $display("test half width done");
    endtask

    task automatic test_calendar();
        logic [63:0] v;
        @(posedge clk);
        fullWidth <= 1'b1;
        countUpA <= 1'b0;
        modeA <= split_timer_pkg::MODE_ONESHOT;
        pulse(1'b1, 1'b0);
        check(64'(calendarRunning), 64'h0);
        // Full-width count of 2 runs out in three cycles: no prescaler stretch
        tick();
        check(64'(timeoutA), 64'h1);
        @(posedge clk);
        modeA <= split_timer_pkg::MODE_RTC;
        // The one-shot has halted; a load applies at once, but the count holds while the calendar is off
        wr(1'b1, 1'b0, split_timer_pkg::SEL_A, 64'h100);
        check(valueA, 64'h100);
        pulse(1'b1, 1'b0);
        check(64'(calendarRunning), 64'h1);
        check(valueA, 64'h100);
        v = valueA;
        repeat (3) tick();
        check(valueA, v - 64'h3);
        pulse(1'b0, 1'b1);
        check(64'(calendarRunning), 64'h0);
        v = valueA;
        repeat (5) tick();
        check(valueA, v);
        $display("test calendar done");
    endtask

    task automatic test_edges();
        split_timer_pkg::edge_t kinds[3];
        logic [31:0] expect_cnt[3];
        logic expect_match[3];
        kinds = '{split_timer_pkg::EDGE_RISE, split_timer_pkg::EDGE_FALL,
                  split_timer_pkg::EDGE_BOTH};
        expect_cnt = '{32'h2, 32'h2, 32'h4};
        expect_match = '{1'b1, 1'b1, 1'b0};
        @(posedge clk);
        fullWidth <= 1'b0;
        modeB <= split_timer_pkg::MODE_EDGECOUNT;
        countUpB <= 1'b1;
        // Match of 2 with prescale match 0: hit only where the count stops at 2
        @(posedge clk);
        matchWr <= 1'b1;
        wrSel <= split_timer_pkg::SEL_B;
        wrData <= 64'h2;
        @(posedge clk);
        matchWr <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            edgeSelB <= kinds[k];
            sync(24'h00_2000);
            repeat (4) begin
                repeat (3) @(posedge clk);
                captureB <= ~captureB;
            end
            repeat (4) tick();
            check(64'(valueB), 64'(expect_cnt[k]));
            check(64'(matchB), 64'(expect_match[k]));
        end
        $display("test edge count done");
    endtask

    initial begin
        rstn = 1'b0;
        fullWidth = 1'b0;
        modeA = split_timer_pkg::MODE_PERIODIC;
        modeB = split_timer_pkg::MODE_PERIODIC;
        edgeSelA = split_timer_pkg::EDGE_RISE;
        edgeSelB = split_timer_pkg::EDGE_RISE;
        {countUpA, countUpB, enableA, enableB} = 4'h0;
        {calendarEnSet, calendarEnClr, captureA, captureB} = 4'h0;
        {loadWr, matchWr, preWr, preMatchWr, syncWrite} = 5'h00;
        wrSel = 2'h0;
        wrData = 64'h0;
        syncMask = 24'h00_0000;
        repeat (12) @(posedge clk);
        #1;
        check(valueA, 64'h0);
        check(64'(syncOut), 64'h0);
        check(64'(calendarRunning), 64'h0);
        @(posedge clk);
        rstn <= 1'b1;
        test_full();
        test_half();
        test_calendar();
        test_edges();
        end_of_test();
    end
endmodule
`default_nettype wire
